// file: inc/vpa_pkg.sv
// constants for the picture adjust stage: register sub-addresses, reset
// values, clip limits, active line windows and fixed-point scales.
// assumes 8-bit luma and offset-binary chroma on the rec. 601 scale.
//
// Contract
// - with pivot select 0 the luma result is gain times (luma minus 128) plus 125.
// - with pivot select 1 the luma result is gain times (luma minus 128) plus 16.
// - the 8-bit contrast gain is a coefficient of 0 to about 1.99 in 1/128 steps, 0x80 is unity.
// - the contrast result clips to 1..254, or to 16..235 when the 601 limit is on.
// - the brightness register is added to luma as a signed offset of -128..+127.
// - the brightness sum clips to 1..254, or to 16..235 when the 601 limit is on.
// - chroma is scaled by the saturation register in 1/128 steps, 0x80 leaves it unchanged.
// - chroma phase turns by the signed hue register, about 0.35 degrees a step, zero is none.
// - on 525-line input lines 22..261 and 285..524 are active, all others are blanking.
// - on 625-line input lines 23..310 and 336..623 are active, all others are blanking.
// - by default blanking lines show black, luma 0x10 and both chroma 0x80.
// - pivot select is bit 7 of the control register at sub-address 0x04, reset 0.
// - contrast gain resets to 0x80 and brightness to 0x00, so at reset luma leaves 3 codes below its pedestal-moved value.
// - the luma pedestal is moved to code 16 before adjustment for either sync amplitude.
package vpa_pkg;
    // ----------------------------------------
    // register sub-addresses and reset values
    // ----------------------------------------
    localparam logic [7:0] VPA_ADDR_CONTROL_B = 8'h04;
    localparam logic [7:0] VPA_ADDR_CONTRAST = 8'h06;
    localparam logic [7:0] VPA_ADDR_BRIGHTNESS = 8'h07;
    localparam logic [7:0] VPA_ADDR_SATURATION = 8'h08;
    localparam logic [7:0] VPA_ADDR_HUE = 8'h09;
    localparam logic [7:0] VPA_RST_CONTROL_B = 8'h00;
    localparam logic [7:0] VPA_RST_CONTRAST = 8'h80;
    localparam logic [7:0] VPA_RST_BRIGHTNESS = 8'h00;
    localparam logic [7:0] VPA_RST_SATURATION = 8'h80;
    localparam logic [7:0] VPA_RST_HUE = 8'h00;
    localparam int VPA_PIVOT_BIT = 7;
    // ----------------------------------------
    // luma arithmetic and clip limits
    // ----------------------------------------
    localparam logic signed [19:0] VPA_LUMA_CENTER = 20'sh0_0080;
    localparam logic signed [19:0] VPA_PIVOT_MID = 20'sh0_007D;
    localparam logic signed [19:0] VPA_PIVOT_LOW = 20'sh0_0010;
    localparam logic signed [19:0] VPA_PEDESTAL = 20'sh0_0010;
    localparam logic signed [19:0] VPA_CLIP_LO = 20'sh0_0001;
    localparam logic signed [19:0] VPA_CLIP_HI = 20'sh0_00FE;
    localparam logic signed [19:0] VPA_CLIP601_LO = 20'sh0_0010;
    localparam logic signed [19:0] VPA_CLIP601_HI = 20'sh0_00EB;
    localparam logic signed [19:0] VPA_FULL_LO = 20'sh0_0000;
    localparam logic signed [19:0] VPA_FULL_HI = 20'sh0_00FF;
    localparam int VPA_GAIN_SHIFT = 7;
    // ----------------------------------------
    // chroma arithmetic, hue in q12
    // ----------------------------------------
    localparam logic signed [19:0] VPA_CHROMA_LO = -20'sh0_0080;
    localparam logic signed [19:0] VPA_CHROMA_HI = 20'sh0_007F;
    // two more bits than the fraction: 13 signed bits would read 0x1000 as -4096
    localparam logic signed [13:0] VPA_HUE_ONE = 14'sh1000;
    localparam logic signed [12:0] VPA_HUE_STEP = 13'sh0019;
    localparam logic [9:0] VPA_HUE_COS_MUL = 10'h271;
    localparam int VPA_HUE_COS_SHIFT = 13;
    localparam int VPA_HUE_SHIFT = 12;
    // ----------------------------------------
    // active line windows and black level
    // ----------------------------------------
    localparam logic [9:0] VPA_L525_A0 = 10'h016;
    localparam logic [9:0] VPA_L525_B0 = 10'h105;
    localparam logic [9:0] VPA_L525_A1 = 10'h11D;
    localparam logic [9:0] VPA_L525_B1 = 10'h20C;
    localparam logic [9:0] VPA_L625_A0 = 10'h017;
    localparam logic [9:0] VPA_L625_B0 = 10'h136;
    localparam logic [9:0] VPA_L625_A1 = 10'h150;
    localparam logic [9:0] VPA_L625_B1 = 10'h26F;
    localparam logic [7:0] VPA_BLACK_LUMA = 8'h10;
    localparam logic [7:0] VPA_BLACK_CHROMA = 8'h80;
endpackage

// file: design/vpa_picture_adjust.sv
// picture adjust stage: pedestal, contrast, brightness, saturation, hue and
// vertical blanking black fill, two register stages from sample to output.
// assumes the sub-address register port is driven by the control interface
// slave and that line_number and system_625 come from sync separation.
`timescale 1ns/10ps
`default_nettype none
module vpa_picture_adjust
    import vpa_pkg::*;
#(
    parameter logic [7:0] PEDESTAL_286_CODE = 8'h0E,
    parameter logic [7:0] PEDESTAL_300_CODE = 8'h10
)(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic rec601_limit,
    input wire logic vblank_pass_en,
    input wire logic sync_300mv,
    input wire logic system_625,
    input wire logic [9:0] line_number,
    input wire logic sample_valid,
    input wire logic [7:0] luma_in,
    input wire logic [7:0] cb_in,
    input wire logic [7:0] cr_in,
    output logic out_valid,
    output logic [7:0] luma_out,
    output logic [7:0] cb_out,
    output logic [7:0] cr_out
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] clip8(input logic signed [19:0] val,
                                         input logic signed [19:0] lo,
                                         input logic signed [19:0] hi);
        logic signed [19:0] res;
        res = val;
        if (val < lo)
        begin
            res = lo;
        end
        else if (val > hi)
        begin
            res = hi;
        end
        return res[7:0];
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] decoder_control_b;
    logic [7:0] contrast_gain_reg;
    logic [7:0] brightness_offset_reg;
    logic [7:0] saturation_gain_reg;
    logic [7:0] hue_rotation_reg;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            decoder_control_b <= VPA_RST_CONTROL_B;
            contrast_gain_reg <= VPA_RST_CONTRAST;
            brightness_offset_reg <= VPA_RST_BRIGHTNESS;
            saturation_gain_reg <= VPA_RST_SATURATION;
            hue_rotation_reg <= VPA_RST_HUE;
        end
        else if (reg_wr)
        begin
            if (reg_addr == VPA_ADDR_CONTROL_B)
            begin
                decoder_control_b <= reg_wdata;
            end
            else if (reg_addr == VPA_ADDR_CONTRAST)
            begin
                contrast_gain_reg <= reg_wdata;
            end
            else if (reg_addr == VPA_ADDR_BRIGHTNESS)
            begin
                brightness_offset_reg <= reg_wdata;
            end
            else if (reg_addr == VPA_ADDR_SATURATION)
            begin
                saturation_gain_reg <= reg_wdata;
            end
            else if (reg_addr == VPA_ADDR_HUE)
            begin
                hue_rotation_reg <= reg_wdata;
            end
        end
    end

    // unmapped sub-addresses read as zero; data held between reads
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            if (reg_addr == VPA_ADDR_CONTROL_B)
            begin
                reg_rdata <= decoder_control_b;
            end
            else if (reg_addr == VPA_ADDR_CONTRAST)
            begin
                reg_rdata <= contrast_gain_reg;
            end
            else if (reg_addr == VPA_ADDR_BRIGHTNESS)
            begin
                reg_rdata <= brightness_offset_reg;
            end
            else if (reg_addr == VPA_ADDR_SATURATION)
            begin
                reg_rdata <= saturation_gain_reg;
            end
            else if (reg_addr == VPA_ADDR_HUE)
            begin
                reg_rdata <= hue_rotation_reg;
            end
            else
            begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ----------------------------------------
    // stage 1: pedestal, contrast, saturation
    // ----------------------------------------
    logic pivot_low;
    logic signed [19:0] lim_lo;
    logic signed [19:0] lim_hi;
    logic signed [19:0] ped_code;
    logic signed [19:0] luma_ped;
    logic signed [19:0] contrast_prod;
    logic signed [19:0] contrast_val;
    logic signed [19:0] cb_prod;
    logic signed [19:0] cr_prod;

    assign pivot_low = decoder_control_b[VPA_PIVOT_BIT];
    assign lim_lo = rec601_limit ? VPA_CLIP601_LO : VPA_CLIP_LO;
    assign lim_hi = rec601_limit ? VPA_CLIP601_HI : VPA_CLIP_HI;
    assign ped_code = {12'h000, (sync_300mv ? PEDESTAL_300_CODE : PEDESTAL_286_CODE)};
    // pedestal lands on 16 for either clamp level, floor at 0
    assign luma_ped = $signed({12'h000, luma_in}) - ped_code + VPA_PEDESTAL;
    // gain is unsigned q1.7, so 0x80 is exactly one
    assign contrast_prod = $signed({12'h000, contrast_gain_reg})
                         * ($signed({12'h000, clip8(luma_ped, VPA_FULL_LO, VPA_FULL_HI)}) - VPA_LUMA_CENTER);
    assign contrast_val = (contrast_prod >>> VPA_GAIN_SHIFT)
                        + (pivot_low ? VPA_PIVOT_LOW : VPA_PIVOT_MID);
    assign cb_prod = $signed({12'h000, saturation_gain_reg})
                   * ($signed({12'h000, cb_in}) - VPA_LUMA_CENTER);
    assign cr_prod = $signed({12'h000, saturation_gain_reg})
                   * ($signed({12'h000, cr_in}) - VPA_LUMA_CENTER);

    logic [7:0] luma_s1_reg;
    logic signed [7:0] cb_s1_reg;
    logic signed [7:0] cr_s1_reg;
    logic valid_s1_reg;
    logic active_s1_reg;
    logic active_now;

    always_comb
    begin
        if (system_625)
        begin
            active_now = (line_number >= VPA_L625_A0 && line_number <= VPA_L625_B0)
                       || (line_number >= VPA_L625_A1 && line_number <= VPA_L625_B1);
        end
        else
        begin
            active_now = (line_number >= VPA_L525_A0 && line_number <= VPA_L525_B0)
                       || (line_number >= VPA_L525_A1 && line_number <= VPA_L525_B1);
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            luma_s1_reg <= VPA_BLACK_LUMA;
            cb_s1_reg <= 8'sh00;
            cr_s1_reg <= 8'sh00;
            valid_s1_reg <= 1'b0;
            active_s1_reg <= 1'b0;
        end
        else
        begin
            luma_s1_reg <= clip8(contrast_val, lim_lo, lim_hi);
            cb_s1_reg <= clip8(cb_prod >>> VPA_GAIN_SHIFT, VPA_CHROMA_LO, VPA_CHROMA_HI);
            cr_s1_reg <= clip8(cr_prod >>> VPA_GAIN_SHIFT, VPA_CHROMA_LO, VPA_CHROMA_HI);
            valid_s1_reg <= sample_valid;
            active_s1_reg <= active_now;
        end
    end

    // ----------------------------------------
    // stage 2: brightness, hue, blanking
    // ----------------------------------------
    // small-angle rotation: sin ~ a, cos ~ 1 - a*a/2; about 10 percent
    // long on sin at the +-45 degree ends, exact near zero
    logic signed [19:0] hue_val;
    logic signed [19:0] hue_sin;
    logic signed [19:0] hue_cos;
    logic signed [19:0] bright_val;
    logic signed [19:0] cb_rot;
    logic signed [19:0] cr_rot;
    logic signed [31:0] hue_sq;
    logic signed [31:0] cb_mix;
    logic signed [31:0] cr_mix;

    assign hue_val = {{12{hue_rotation_reg[7]}}, hue_rotation_reg};
    assign hue_sin = hue_val * VPA_HUE_STEP;
    // square and rotation sums kept at 32 bits: 20 bits wrap at large hue
    assign hue_sq = hue_val * hue_val * $signed({22'h00_0000, VPA_HUE_COS_MUL});
    assign hue_cos = VPA_HUE_ONE - 20'(hue_sq >>> VPA_HUE_COS_SHIFT);
    assign bright_val = $signed({12'h000, luma_s1_reg})
                      + $signed({{12{brightness_offset_reg[7]}}, brightness_offset_reg});
    assign cb_mix = cb_s1_reg * hue_cos - cr_s1_reg * hue_sin;
    assign cr_mix = cr_s1_reg * hue_cos + cb_s1_reg * hue_sin;
    assign cb_rot = 20'(cb_mix >>> VPA_HUE_SHIFT);
    assign cr_rot = 20'(cr_mix >>> VPA_HUE_SHIFT);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            luma_out <= VPA_BLACK_LUMA;
            cb_out <= VPA_BLACK_CHROMA;
            cr_out <= VPA_BLACK_CHROMA;
            out_valid <= 1'b0;
        end
        else if (!active_s1_reg && !vblank_pass_en)
        begin
            luma_out <= VPA_BLACK_LUMA;
            cb_out <= VPA_BLACK_CHROMA;
            cr_out <= VPA_BLACK_CHROMA;
            out_valid <= valid_s1_reg;
        end
        else
        begin
            luma_out <= clip8(bright_val, lim_lo, lim_hi);
            cb_out <= clip8(cb_rot, VPA_CHROMA_LO, VPA_CHROMA_HI) ^ VPA_BLACK_CHROMA;
            cr_out <= clip8(cr_rot, VPA_CHROMA_LO, VPA_CHROMA_HI) ^ VPA_BLACK_CHROMA;
            out_valid <= valid_s1_reg;
        end
    end

endmodule // vpa_picture_adjust
`default_nettype wire

// file: sim/vpa_asserts.sv
// checker for the picture adjust stage ports
// assumes it is bound to vpa_picture_adjust and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module vpa_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic rec601_limit,
    input wire logic vblank_pass_en,
    input wire logic system_625,
    input wire logic [9:0] line_number,
    input wire logic sample_valid,
    input wire logic out_valid,
    input wire logic [7:0] luma_out,
    input wire logic [7:0] cb_out,
    input wire logic [7:0] cr_out
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    wire logic mapped = reg_addr inside {8'h04, 8'h06, 8'h07, 8'h08, 8'h09};
    wire logic act525 = line_number inside {[10'd22:10'd261], [10'd285:10'd524]};
    wire logic act625 = line_number inside {[10'd23:10'd310], [10'd336:10'd623]};
    default clocking dclk @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_valid_two_stage: assert property (out_valid == $past(sample_valid, 2))
        else $error("out_valid does not follow sample_valid by two cycles");
    a_luma_full_range: assert property (out_valid && !$past(rec601_limit, 2) |-> luma_out inside {[1:254]})
        else $error("luma outside 1..254");
    a_luma_601_range: assert property (out_valid && $past(rec601_limit, 2) |-> luma_out inside {[16:235]})
        else $error("luma outside 16..235");
    a_blank_black_525: assert property (sample_valid && !vblank_pass_en && !system_625 && !act525
        |-> ##2 {luma_out, cb_out, cr_out} == 24'h10_8080)
        else $error("525 blanking line not black");
    a_blank_black_625: assert property (sample_valid && !vblank_pass_en && system_625 && !act625
        |-> ##2 {luma_out, cb_out, cr_out} == 24'h10_8080)
        else $error("625 blanking line not black");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_write_readback: assert property (reg_wr && mapped ##1 reg_rd && !reg_wr && $stable(reg_addr)
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("register readback differs from write");
endmodule // vpa_asserts
bind vpa_picture_adjust vpa_asserts u_chk (.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .rec601_limit, .vblank_pass_en, .system_625, .line_number, .sample_valid, .out_valid, .luma_out, .cb_out, .cr_out);
`default_nettype wire

// file: sim/vpa_sink_model.sv
// downstream formatter model: keeps every valid output sample in order
// assumes no back-pressure, one sample per valid cycle
`timescale 1ns/10ps
`default_nettype none
module vpa_sink_model (
    input wire logic clk,
    input wire logic out_valid,
    input wire logic [7:0] luma_out,
    input wire logic [7:0] cb_out,
    input wire logic [7:0] cr_out
);
    logic [23:0] q [$];
    // sampled at the edge, so values are those launched one edge earlier
    always @(posedge clk)
    begin
        if (out_valid === 1'b1)
            q.push_back({luma_out, cb_out, cr_out});
    end
endmodule // vpa_sink_model
`default_nettype wire

// file: sim/tb.sv
// bench for the picture adjust stage: register access and pixel arithmetic
// assumes the checker bind and the sink model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rec601_limit = 1'b0;
    logic vblank_pass_en = 1'b0;
    logic sync_300mv = 1'b1;
    logic system_625 = 1'b0;
    logic sample_valid = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] luma_in = 8'h00;
    logic [7:0] cb_in = 8'h80;
    logic [7:0] cr_in = 8'h80;
    logic [9:0] line_number = 10'h064;
    logic [7:0] reg_rdata, luma_out, cb_out, cr_out;
    logic out_valid;
    int bad_count = 0;
    int n_checks = 0;
    int seed = 32'he60d_ce4f;
    logic [7:0] sh [16];
    logic [23:0] eq [$];
    logic [7:0] ra [7] = '{8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h05, 8'h0A};
    logic [7:0] rv [7] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
    logic [9:0] bl [2][8] = '{'{21, 22, 261, 262, 284, 285, 524, 525}, '{22, 23, 310, 311, 335, 336, 623, 624}};
    vpa_picture_adjust #(.PEDESTAL_286_CODE(8'h0E), .PEDESTAL_300_CODE(8'h10)) dut (.clk, .rst_b, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .rec601_limit, .vblank_pass_en, .sync_300mv, .system_625,
        .line_number, .sample_valid, .luma_in, .cb_in, .cr_in, .out_valid, .luma_out, .cb_out, .cr_out);
    vpa_sink_model u_sink (.clk, .out_valid, .luma_out, .cb_out, .cr_out);
    initial
    begin
        forever #25 clk = ~clk;
    end
    // ----------------------------------------
    // expectation and checking
    // ----------------------------------------
    function automatic int clip(int v, int lo, int hi);
        return v < lo ? lo : (v > hi ? hi : v);
    endfunction
    function automatic logic [23:0] model(logic [7:0] y, logic [7:0] b, logic [7:0] r, logic [9:0] ln);
        int lo, hi, yp, u, v, h, s, c;
        lo = rec601_limit ? 16 : 1;
        hi = rec601_limit ? 235 : 254;
        if (!vblank_pass_en && !(system_625 ? ln inside {[23:310], [336:623]} : ln inside {[22:261], [285:524]}))
            return 24'h10_8080;
        yp = clip(int'(y) - (sync_300mv ? 16 : 14) + 16, 0, 255);
        yp = clip(((int'(sh[6]) * (yp - 128)) >>> 7) + (sh[4][7] ? 16 : 125), lo, hi);
        yp = clip(yp + int'($signed(sh[7])), lo, hi);
        u = clip((int'(sh[8]) * (int'(b) - 128)) >>> 7, -128, 127);
        v = clip((int'(sh[8]) * (int'(r) - 128)) >>> 7, -128, 127);
        h = int'($signed(sh[9]));
        s = h * 25;
        c = 4096 - ((h * h * 625) >>> 13);
        return {yp[7:0], 8'(clip((u * c - v * s) >>> 12, -128, 127) + 128),
            8'(clip((v * c + u * s) >>> 12, -128, 127) + 128)};
    endfunction
    function automatic logic [9:0] rl();
        return 10'(1 + $unsigned($random(seed)) % (system_625 ? 625 : 525));
    endfunction
    task automatic chk(string nm, logic [23:0] got, logic [23:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // drivers, changed 1 ns after the edge
    // ----------------------------------------
    task automatic wr(logic [7:0] a, logic [7:0] d);
        // idle edge first so a strobe is never dropped and raised in one step
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        if (a inside {8'h04, 8'h06, 8'h07, 8'h08, 8'h09})
            sh[a[3:0]] = d;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        chk("reg_rdata", {16'h0000, reg_rdata}, {16'h0000, exp});
        @(posedge clk);
        #1;
    endtask
    task automatic px(logic [7:0] y, logic [9:0] ln);
        luma_in = y;
        cb_in = 8'($random(seed));
        cr_in = 8'($random(seed));
        line_number = ln;
        sample_valid = 1'b1;
        eq.push_back(model(y, cb_in, cr_in, ln));
        @(posedge clk);
        #1;
    endtask
    task automatic drain();
        sample_valid = 1'b0;
        for (int k = 0; k < 8 && u_sink.q.size() < eq.size(); k++)
            @(posedge clk);
        #1;
        if (u_sink.q.size() < eq.size())
        begin
            bad_count++;
            test_done();
        end
        while (eq.size() > 0)
            chk("pixel", u_sink.q.pop_front(), eq.pop_front());
        u_sink.q.delete();
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0] d;
        sh = '{default: 8'h00};
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            rd(ra[i], rv[i]);
            sh[ra[i][3:0]] = rv[i];
        end
        $display("test reset values done");
        for (int i = 0; i < 8; i++)
            px(8'($random(seed)), 10'h064);
        drain();
        $display("test default pixels done");
        for (int i = 0; i < 7; i++)
        begin
            d = 8'($random(seed));
            wr(ra[i], d);
            rd(ra[i], i < 5 ? d : 8'h00);
        end
        $display("test register access done");
        for (int it = 0; it < 40; it++)
        begin
            {rec601_limit, vblank_pass_en, sync_300mv, system_625} = 4'($random(seed));
            wr(8'h04, 8'($random(seed)));
            wr(8'h06, it == 0 ? 8'hFF : 8'($random(seed)));
            wr(8'h07, it == 0 ? 8'h7F : (it == 1 ? 8'h81 : 8'($random(seed) % 128)));
            wr(8'h08, 8'($random(seed)));
            wr(8'h09, 8'($random(seed)));
            for (int j = 0; j < 10; j++)
                px(j == 0 ? 8'h00 : (j == 1 ? 8'hFF : 8'($random(seed))), j < 8 ? bl[system_625][j] : rl());
            drain();
        end
        $display("test pixel adjust done");
        test_done();
    end
endmodule // tb
`default_nettype wire
